// File: cste_top.sv
// Charge status indicator and battery temperature event logic
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cste_top (
	input  wire logic                     sys_clk,
	input  wire logic                     reset_n,
	input  wire cste_pkg::cste_chg_state_t chargerState,
	input  wire cste_pkg::cste_therm_t     thermistorSense,
	input  wire logic                     chargeActiveIndicatorIn,
	output logic                          chargeActiveIndicatorOut,
	output logic                          chargeActiveIndicatorOe,
	output logic                          chargeSuspend,
	output logic                          irq,
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready
);

	// ==========================================================
	// Charger state decode
	function automatic logic [1:0] stateCode(
		input cste_pkg::cste_chg_state_t st
	);
		case (st)
			cste_pkg::CSTE_CHG_PRECOND: stateCode = cste_pkg::CSTE_CODE_PRECOND;
			cste_pkg::CSTE_CHG_FAST,
			cste_pkg::CSTE_CHG_TOPOFF:  stateCode = cste_pkg::CSTE_CODE_FAST;
			cste_pkg::CSTE_CHG_EOC:     stateCode = cste_pkg::CSTE_CODE_EOC;
			default:                    stateCode = cste_pkg::CSTE_CODE_IDLE;
		endcase
	endfunction

	// Register select on the word index of a byte address
	function automatic logic regHit(
		input logic [7:0] addr,
		input logic [7:0] offset
	);
		regHit = (addr[7:2] == offset[7:2]);
	endfunction

	function automatic logic regMapped(
		input logic [7:0] addr
	);
		regMapped = regHit(addr, cste_pkg::CSTE_OFF_CTRL) ||
			regHit(addr, cste_pkg::CSTE_OFF_STATUS) ||
			regHit(addr, cste_pkg::CSTE_OFF_MASK) ||
			regHit(addr, cste_pkg::CSTE_OFF_STATE);
	endfunction

	logic       outOfRange;
	logic       inRange;
	logic [1:0] codeNow;
	assign outOfRange = thermistorSense.beyondHot |
		thermistorSense.beyondCold;
	assign inRange = ~outOfRange;
	assign codeNow = stateCode(chargerState);

	// ==========================================================
	// State registers
	logic [2:0]  ctrl_reg, ctrl_next;
	logic        mask_reg, mask_next;
	logic        temp_irq_status_reg, temp_irq_status_next;
	logic        inRange_reg, inRange_next;
	logic        indicator_reg, indicator_next;
	logic        suspend_reg, suspend_next;
	logic [1:0]  code_reg, code_next;
	logic        awHeld_reg, awHeld_next;
	logic        wHeld_reg, wHeld_next;
	logic [7:0]  awAddr_reg, awAddr_next;
	logic [31:0] wData_reg, wData_next;
	logic [3:0]  wStrb_reg, wStrb_next;
	logic        bValid_reg, bValid_next;
	logic [1:0]  bResp_reg, bResp_next;
	logic        rValid_reg, rValid_next;
	logic [31:0] rData_reg, rData_next;
	logic [1:0]  rResp_reg, rResp_next;

	logic exitEvent;
	logic returnEvent;
	logic tempEvent;
	logic doWrite;
	logic doRead;
	logic [7:0] wAddr;
	logic [31:0] wDat;
	logic [3:0] wStb;
	logic [7:0] rAddr;
	logic       statusRead;
	logic       statusClear;

	assign s_axi_awready = ~awHeld_reg & ~bValid_reg;
	assign s_axi_wready  = ~wHeld_reg & ~bValid_reg;
	assign s_axi_arready = ~rValid_reg;
	assign s_axi_bvalid  = bValid_reg;
	assign s_axi_bresp   = bResp_reg;
	assign s_axi_rvalid  = rValid_reg;
	assign s_axi_rdata   = rData_reg;
	assign s_axi_rresp   = rResp_reg;
	assign rAddr         = s_axi_araddr;

	// ==========================================================
	// Write channel: address and data are taken in either order
	always_comb begin
		awHeld_next = awHeld_reg;
		wHeld_next  = wHeld_reg;
		awAddr_next = awAddr_reg;
		wData_next  = wData_reg;
		wStrb_next  = wStrb_reg;
		bValid_next = bValid_reg;
		bResp_next  = bResp_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_next = 1'b1;
			awAddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_next = 1'b1;
			wData_next = s_axi_wdata;
			wStrb_next = s_axi_wstrb;
		end
		doWrite = awHeld_next & wHeld_next & ~bValid_reg;
		wAddr   = awAddr_next;
		wDat    = wData_next;
		wStb    = wStrb_next;
		if (doWrite) begin
			awHeld_next = 1'b0;
			wHeld_next  = 1'b0;
			bValid_next = 1'b1;
			if (regMapped(wAddr))
				bResp_next = cste_pkg::CSTE_RESP_OKAY;
			else
				bResp_next = cste_pkg::CSTE_RESP_SLVERR;
		end else if (bValid_reg && s_axi_bready) begin
			bValid_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			awHeld_reg <= 1'b0;
			wHeld_reg  <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg  <= 32'h0000_0000;
			wStrb_reg  <= 4'h0;
			bValid_reg <= 1'b0;
			bResp_reg  <= cste_pkg::CSTE_RESP_OKAY;
		end else begin
			awHeld_reg <= awHeld_next;
			wHeld_reg  <= wHeld_next;
			awAddr_reg <= awAddr_next;
			wData_reg  <= wData_next;
			wStrb_reg  <= wStrb_next;
			bValid_reg <= bValid_next;
			bResp_reg  <= bResp_next;
		end
	end

	// ==========================================================
	// Control and mask registers, all fields in byte lane 0
	always_comb begin
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		if (doWrite && wStb[0]) begin
			if (regHit(wAddr, cste_pkg::CSTE_OFF_CTRL)) begin
				ctrl_next = wDat[2:0];
			end else if (regHit(wAddr, cste_pkg::CSTE_OFF_MASK)) begin
				mask_next = wDat[0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= cste_pkg::CSTE_CTRL_RESET;
			mask_reg <= cste_pkg::CSTE_MASK_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
		end
	end

	// ==========================================================
	// Read channel: data is captured when the address is taken
	always_comb begin
		doRead      = s_axi_arvalid & s_axi_arready;
		rValid_next = rValid_reg;
		rData_next  = rData_reg;
		rResp_next  = rResp_reg;
		if (doRead) begin
			rValid_next = 1'b1;
			rResp_next  = cste_pkg::CSTE_RESP_OKAY;
			rData_next  = 32'h0000_0000;
			if (regHit(rAddr, cste_pkg::CSTE_OFF_CTRL)) begin
				rData_next[2:0] = ctrl_reg;
			end else if (regHit(rAddr, cste_pkg::CSTE_OFF_STATUS)) begin
				rData_next[cste_pkg::CSTE_STAT_TEMP] = temp_irq_status_reg;
				rData_next[cste_pkg::CSTE_STAT_INRANGE] = inRange_reg;
			end else if (regHit(rAddr, cste_pkg::CSTE_OFF_MASK)) begin
				rData_next[0] = mask_reg;
			end else if (regHit(rAddr, cste_pkg::CSTE_OFF_STATE)) begin
				rData_next[cste_pkg::CSTE_STATE_CODE_LSB +: 2] = code_reg;
				rData_next[cste_pkg::CSTE_STATE_SUSP_BIT] = suspend_reg;
			end else begin
				rResp_next = cste_pkg::CSTE_RESP_SLVERR;
			end
		end else if (rValid_reg && s_axi_rready) begin
			rValid_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rValid_reg <= 1'b0;
			rData_reg  <= 32'h0000_0000;
			rResp_reg  <= cste_pkg::CSTE_RESP_OKAY;
		end else begin
			rValid_reg <= rValid_next;
			rData_reg  <= rData_next;
			rResp_reg  <= rResp_next;
		end
	end

	// ==========================================================
	// Temperature range tracking and pending status
	always_comb begin
		inRange_next = inRange;
		exitEvent = inRange_reg & ~inRange &
			ctrl_reg[cste_pkg::CSTE_CTRL_EXIT_EN];
		returnEvent = ~inRange_reg & inRange &
			ctrl_reg[cste_pkg::CSTE_CTRL_RETURN_EN];
		tempEvent = (exitEvent | returnEvent) &
			ctrl_reg[cste_pkg::CSTE_CTRL_STAT_EN];
		statusRead = doRead & regHit(rAddr, cste_pkg::CSTE_OFF_STATUS);
		// Write one to clear, as well as read to clear
		statusClear = doWrite & wStb[0] & wDat[cste_pkg::CSTE_STAT_TEMP] &
			regHit(wAddr, cste_pkg::CSTE_OFF_STATUS);
		temp_irq_status_next = temp_irq_status_reg;
		if (statusRead || statusClear)
			temp_irq_status_next = 1'b0;
		// Set wins over a clearing read or write
		if (tempEvent)
			temp_irq_status_next = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			temp_irq_status_reg <= 1'b0;
			inRange_reg  <= 1'b1;
		end else begin
			temp_irq_status_reg <= temp_irq_status_next;
			inRange_reg  <= inRange_next;
		end
	end

	// ==========================================================
	// Indicator, suspend and state code
	always_comb begin
		indicator_next = (codeNow == cste_pkg::CSTE_CODE_PRECOND) ||
			(codeNow == cste_pkg::CSTE_CODE_FAST);
		suspend_next = outOfRange;
		code_next    = codeNow;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			indicator_reg <= 1'b0;
			suspend_reg   <= 1'b0;
			code_reg      <= cste_pkg::CSTE_CODE_IDLE;
		end else begin
			indicator_reg <= indicator_next;
			suspend_reg   <= suspend_next;
			code_reg      <= code_next;
		end
	end

	// ==========================================================
	// Outputs
	// Open drain: drive low while charging, released otherwise
	assign chargeActiveIndicatorOut = 1'b0;
	assign chargeActiveIndicatorOe  = indicator_reg;
	assign chargeSuspend = suspend_reg;
	assign irq = temp_irq_status_reg & mask_reg;

endmodule
`default_nettype wire

// File: cste_pkg.sv
// Package of constants and types for the charge status and temperature events
//
// Summary of operation
// - Indicator sinks current in precondition, fast-charge and top-off states.
// - Indicator is released in all other charger states.
// - Charging is suspended while thermistor sense is beyond hot or cold limit.
// - Exit enable and status enable both set: interrupt on leaving valid range.
// - Return enable and status enable both set: interrupt on re-entering range.
// - Live in-range flag reads 1 inside valid range, 0 outside.
// - Pending temperature status reads 1 and is cleared by that read.
// - Temperature status reads 0 when nothing is pending.
// - Two-bit state code: 11 precondition, 10 fast/top-off, 01 EOC, 00 other.
`default_nettype none
package cste_pkg;

	// Register byte offsets
	localparam logic [7:0] CSTE_OFF_CTRL   = 8'h00;
	localparam logic [7:0] CSTE_OFF_STATUS = 8'h04;
	localparam logic [7:0] CSTE_OFF_MASK   = 8'h08;
	localparam logic [7:0] CSTE_OFF_STATE  = 8'h0C;

	// Control register fields
	localparam int CSTE_CTRL_EXIT_EN   = 0;
	localparam int CSTE_CTRL_RETURN_EN = 1;
	localparam int CSTE_CTRL_STAT_EN   = 2;
	localparam logic [2:0] CSTE_CTRL_RESET = 3'h0;

	// Status register fields and mask reset value
	localparam int CSTE_STAT_TEMP    = 0;
	localparam int CSTE_STAT_INRANGE = 1;
	localparam logic CSTE_MASK_RESET = 1'b0;

	// State register fields
	localparam int CSTE_STATE_CODE_LSB = 0;
	localparam int CSTE_STATE_SUSP_BIT = 2;

	// Charge state codes
	localparam logic [1:0] CSTE_CODE_PRECOND = 2'h3;
	localparam logic [1:0] CSTE_CODE_FAST    = 2'h2;
	localparam logic [1:0] CSTE_CODE_EOC     = 2'h1;
	localparam logic [1:0] CSTE_CODE_IDLE    = 2'h0;

	localparam logic [1:0] CSTE_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CSTE_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		CSTE_CHG_PRECOND,
		CSTE_CHG_FAST,
		CSTE_CHG_TOPOFF,
		CSTE_CHG_EOC,
		CSTE_CHG_SUSPEND,
		CSTE_CHG_TEMP_FAULT,
		CSTE_CHG_TIME_FAULT,
		CSTE_CHG_DISABLED
	} cste_chg_state_t;

	// Thermistor window comparator outputs
	typedef struct packed {
		logic beyondHot;
		logic beyondCold;
	} cste_therm_t;

	// Open-drain pin pair
	typedef struct packed {
		logic out;
		logic oe;
	} cste_od_t;

endpackage
`default_nettype wire

// File: cste_monitor.sv
// Checker of indicator, suspend, interrupt and register-read behaviour
`timescale 1ns/1ps
`default_nettype none
module cste_monitor (
	input wire logic                      sys_clk,
	input wire logic                      reset_n,
	input wire cste_pkg::cste_chg_state_t chargerState,
	input wire cste_pkg::cste_therm_t     thermistorSense,
	input wire logic                      chargeActiveIndicatorOut,
	input wire logic                      chargeActiveIndicatorOe,
	input wire logic                      chargeSuspend,
	input wire logic                      irq,
	input wire logic [7:0]                s_axi_araddr,
	input wire logic                      s_axi_arvalid,
	input wire logic                      s_axi_arready,
	input wire logic [31:0]               s_axi_rdata,
	input wire logic [1:0]                s_axi_rresp,
	input wire logic                      s_axi_rvalid,
	input wire logic                      s_axi_rready,
	input wire logic                      s_axi_bvalid
);
	logic inRange;
	logic act;
	logic arTaken;
	logic arStat;
	assign inRange = !(thermistorSense.beyondHot || thermistorSense.beyondCold);
	assign act = chargerState inside {cste_pkg::CSTE_CHG_PRECOND,
		cste_pkg::CSTE_CHG_FAST, cste_pkg::CSTE_CHG_TOPOFF};
	assign arTaken = s_axi_arvalid && s_axi_arready;
	assign arStat = arTaken && s_axi_araddr == cste_pkg::CSTE_OFF_STATUS;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// ==========================================
	// Assertions
	oe_follows_state_a: assert property ($past(reset_n) |->
		chargeActiveIndicatorOe == $past(act)) else $error("indicator wrong");
	od_drive_low_a: assert property (chargeActiveIndicatorOut == 1'b0)
		else $error("open drain drives high");
	suspend_range_a: assert property ($past(reset_n) |->
		chargeSuspend == !$past(inRange)) else $error("suspend wrong");
	irq_cause_a: assert property ($rose(irq) |->
		$past(inRange) != $past(inRange, 2) || $rose(s_axi_bvalid))
		else $error("irq without event");
	status_read_a: assert property (arStat && irq |=>
		s_axi_rvalid && s_axi_rdata[0]) else $error("pending not read");
	irq_release_a: assert property (arStat && inRange == $past(inRange)
		|=> !irq) else $error("irq held after read");
	range_flag_a: assert property (arStat |=>
		s_axi_rdata[1] == $past(inRange, 2)) else $error("range flag wrong");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
	unmapped_a: assert property (arTaken && s_axi_araddr == 8'h10 |=>
		s_axi_rresp == cste_pkg::CSTE_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read accepted");
	irq_seen_c: cover property ($rose(irq));
	oe_seen_c: cover property ($rose(chargeActiveIndicatorOe));
	pend_read_c: cover property (arStat && irq);
endmodule
bind cste_top cste_monitor cste_monitor_inst (.sys_clk, .reset_n,
	.chargerState, .thermistorSense, .chargeActiveIndicatorOut,
	.chargeActiveIndicatorOe, .chargeSuspend, .irq, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .s_axi_bvalid);
`default_nettype wire

// File: cste_host.sv
// Register-bus host model: one write or one read at a time
`timescale 1ns/1ps
`default_nettype none
module cste_host (
	input  wire logic        sys_clk,
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	logic [1:0] writeResp;
	initial begin
		writeResp = 2'h0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'h0;
	end
	// Ready and answers are sampled at the rising edge that completes them
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge sys_clk);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw && w));
		do @(posedge sys_clk); while (!s_axi_bvalid);
		writeResp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench of charge indicator and temperature events
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	cste_pkg::cste_chg_state_t chargerState = cste_pkg::CSTE_CHG_DISABLED;
	cste_pkg::cste_therm_t thermistorSense = 2'b00;
	logic chargeActiveIndicatorOut, chargeActiveIndicatorOe, chargeSuspend, irq;
	logic pinLevel;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, code;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	int failures = 0;
	int cmp_count = 0;
	// Pin has a pull-up: released means high
	assign pinLevel = chargeActiveIndicatorOe ? chargeActiveIndicatorOut : 1'b1;
	always #4 sys_clk = ~sys_clk;
	cste_top cste_top_inst (.sys_clk, .reset_n, .chargerState, .thermistorSense,
		.chargeActiveIndicatorIn(pinLevel), .chargeActiveIndicatorOut,
		.chargeActiveIndicatorOe, .chargeSuspend, .irq, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	cste_host cste_host_inst (.sys_clk, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		cste_host_inst.rd(a, d, r);
		check(d, exp);
	endtask
	task automatic temp(input logic hot, input logic cold);
		@(posedge sys_clk);
		thermistorSense <= {hot, cold};
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic t_reset;
		check({chargeActiveIndicatorOe, irq, chargeSuspend}, 3'h0);
		rdchk(cste_pkg::CSTE_OFF_CTRL, 32'h0000_0000);
		rdchk(cste_pkg::CSTE_OFF_MASK, 32'h0000_0000);
		rdchk(cste_pkg::CSTE_OFF_STATUS, 32'h0000_0002);
		cste_host_inst.rd(8'h10, d, r);
		check(d, 32'h0000_0000);
		check(r, cste_pkg::CSTE_RESP_SLVERR);
	endtask
	task automatic t_mask;
		cste_host_inst.wr(cste_pkg::CSTE_OFF_MASK, 32'h0000_0000);
		check(cste_host_inst.writeResp, cste_pkg::CSTE_RESP_OKAY);
		cste_host_inst.wr(cste_pkg::CSTE_OFF_CTRL, 32'h0000_0007);
		rdchk(cste_pkg::CSTE_OFF_STATE, 32'h0000_0004);
		temp(1'b0, 1'b0);
		check(irq, 1'b0);
		cste_host_inst.wr(cste_pkg::CSTE_OFF_MASK, 32'h0000_0001);
		check(irq, 1'b1);
		cste_host_inst.wr(cste_pkg::CSTE_OFF_STATUS, 32'h0000_0001);
		check(irq, 1'b0);
		rdchk(cste_pkg::CSTE_OFF_STATUS, 32'h0000_0002);
		cste_host_inst.wr(8'h10, 32'h0000_0000);
		check(cste_host_inst.writeResp, cste_pkg::CSTE_RESP_SLVERR);
	endtask
	task automatic t_indicator;
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			chargerState <= cste_pkg::cste_chg_state_t'(i);
			code = (i == 0) ? 2'h3 : (i < 3) ? 2'h2 : (i == 3) ? 2'h1 : 2'h0;
			repeat (2) @(posedge sys_clk);
			@(negedge sys_clk);
			check(chargeActiveIndicatorOe, i < 3);
			check(pinLevel, i >= 3);
			rdchk(cste_pkg::CSTE_OFF_STATE, {30'h0, code});
		end
	endtask
	task automatic t_events;
		cste_host_inst.wr(cste_pkg::CSTE_OFF_CTRL, 32'h0000_0007);
		cste_host_inst.wr(cste_pkg::CSTE_OFF_MASK, 32'h0000_0001);
		temp(1'b1, 1'b0);
		check({irq, chargeSuspend}, 2'h3);
		rdchk(cste_pkg::CSTE_OFF_STATUS, 32'h0000_0001);
		check(irq, 1'b0);
		rdchk(cste_pkg::CSTE_OFF_STATUS, 32'h0000_0000);
		temp(1'b0, 1'b0);
		check({irq, chargeSuspend}, 2'h2);
		rdchk(cste_pkg::CSTE_OFF_STATUS, 32'h0000_0003);
		cste_host_inst.wr(cste_pkg::CSTE_OFF_CTRL, 32'h0000_0005);
		temp(1'b0, 1'b1);
		rdchk(cste_pkg::CSTE_OFF_STATUS, 32'h0000_0001);
		temp(1'b0, 1'b0);
		check(irq, 1'b0);
		cste_host_inst.wr(cste_pkg::CSTE_OFF_CTRL, 32'h0000_0003);
		temp(1'b1, 1'b0);
		check({irq, chargeSuspend}, 2'h1);
		rdchk(cste_pkg::CSTE_OFF_STATUS, 32'h0000_0000);
	endtask
	task automatic results;
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_reset();
		t_indicator();
		t_events();
		t_mask();
		results();
	end
	initial begin
		#100000;
		failures++;
		results();
	end
endmodule
`default_nettype wire
